/* design/sram_port_pkg.sv */
// Summary of operation
// [RL1] Write happens during select, lane, strobe overlap
// [RL2] Output drive low: stretch strobe past float
// [RL3] Output drive high: ordinary minimum strobe pulse
// [RL4] Never drive bus while device drives
// [RL5] Device floats when select follows strobe
// [RL6] Address valid before last select edge
// [RL7] Write strobe stays high during reads
// [RL8] Address-driven reads need no strobe edges
// [RL9] Device is static, needs no clock
// [RL10] Lane enables gate low and high bytes
package sram_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_PS = 5000;
    // Timing figures in ps (slowest grade)
    localparam int T_RC_PS = 20000;
    localparam int T_AA_PS = 20000;
    localparam int T_WP_PS = 12000;
    localparam int T_WHZ_PS = 8000;
    localparam int T_DW_PS = 9000;
    localparam int T_OHZ_PS = 8000;
    // Least times round up
    // Reads add one margin cycle for pin delays and two for the synchroniser
    localparam int RD_CYC = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 3;
    localparam int WP_CYC = (T_WP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WP_LONG_CYC = (T_WHZ_PS + T_DW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FLOAT_CYC = (T_OHZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DW_CYC = (T_DW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_FLOAT, ST_WRITE, ST_RECOVER} ctl_state_e;
endpackage

/* design/sram_host_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
module sram_host_ctl
    import sram_port_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // User request
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [1:0] i_lane_en,
    input wire logic i_keep_out_drive,
    output logic o_ready,
    output logic o_rvalid,
    output logic [DATA_W-1:0] o_rdata,
    // Memory pins
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_mem_sel_n,
    output logic o_mem_wr_n,
    output logic o_mem_out_drive_n,
    output logic o_lower_lane_en_n,
    output logic o_upper_lane_en_n,
    output logic [DATA_W-1:0] o_mem_dq,
    output logic o_mem_dq_oe,
    input wire logic [DATA_W-1:0] i_mem_dq
);
    // ----------------------------------------
    // Pin input synchroniser
    // ----------------------------------------
    // Bus is captured only late in a read, when every bit has long settled, so per-bit flops are safe
    logic [DATA_W-1:0] dq_meta_ff, dq_sync_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dq_meta_ff <= 16'h0000;
            dq_sync_ff <= 16'h0000;
        end else if (i_ce) begin
            dq_meta_ff <= i_mem_dq;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    ctl_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic wr_ff, keep_od_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic [1:0] lane_ff;
    logic rvalid_ff;
    wire cnt_done = (cnt_ff == CNT_ZERO);
    wire take = (state_ff == ST_IDLE) && i_req;
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 4'h1;
        case (state_ff)
            ST_IDLE: begin
                if (i_req) begin
                    nxt_state = i_wr ? (i_keep_out_drive ? ST_FLOAT : ST_WRITE) : ST_READ;
                    nxt_cnt = i_wr ? (i_keep_out_drive ? 4'(FLOAT_CYC - 1)
                        : 4'(WP_CYC - 1)) : 4'(RD_CYC - 1); // [RL3]
                end
            end
            ST_READ: if (cnt_done) nxt_state = ST_RECOVER;
            ST_FLOAT: begin
                // Strobe already low, bus still undriven while device floats
                if (cnt_done) begin
                    nxt_state = ST_WRITE;
                    nxt_cnt = 4'(DW_CYC - 1); // [RL2]
                end
            end
            ST_WRITE: if (cnt_done) nxt_state = ST_RECOVER;
            ST_RECOVER: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ff <= 1'b0;
            keep_od_ff <= 1'b0;
            addr_ff <= 16'h0000;
            wdata_ff <= 16'h0000;
            lane_ff <= 2'h0;
        end else if (i_ce && take) begin
            // Address is latched on the same edge on which select falls
            wr_ff <= i_wr; // [RL6]
            keep_od_ff <= i_keep_out_drive;
            addr_ff <= i_addr;
            wdata_ff <= i_wdata;
            lane_ff <= i_lane_en;
        end
    end

    // ----------------------------------------
    // Read capture
    // ----------------------------------------
    wire rd_done = (state_ff == ST_READ) && cnt_done;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else if (i_ce) begin
            rvalid_ff <= rd_done;
            if (rd_done) begin
                // Unselected lanes read as zero
                rdata_ff <= dq_sync_ff & {{8{lane_ff[1]}}, {8{lane_ff[0]}}}; // [RL10]
            end
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    wire active = (state_ff == ST_READ) || (state_ff == ST_FLOAT) || (state_ff == ST_WRITE);
    wire strobe = (state_ff == ST_FLOAT) || (state_ff == ST_WRITE);
    wire lanes_on = active && (lane_ff != 2'h0);
    assign o_mem_addr = addr_ff;
    // Select and lanes fall together with the strobe; device keeps pins floated then
    assign o_mem_sel_n = ~lanes_on; // [RL1] [RL5]
    assign o_lower_lane_en_n = ~(lanes_on && lane_ff[0]); // [RL10]
    assign o_upper_lane_en_n = ~(lanes_on && lane_ff[1]); // [RL10]
    assign o_mem_wr_n = ~(strobe && lanes_on); // [RL1] [RL7]
    assign o_mem_out_drive_n = ~((state_ff == ST_READ) || ((state_ff == ST_FLOAT || state_ff == ST_WRITE)
        && keep_od_ff));
    // Data only driven after the float window has passed
    assign o_mem_dq_oe = (state_ff == ST_WRITE) && lanes_on; // [RL4]
    assign o_mem_dq = wdata_ff;
    assign o_ready = (state_ff == ST_IDLE);
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Length of the current strobe-low stretch, counted in enabled cycles
    logic [3:0] low_cnt_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_ff <= 4'h0;
        end else if (i_ce) begin
            low_cnt_ff <= o_mem_wr_n ? 4'h0 : low_cnt_ff + 4'h1;
        end
    end

    a_write_overlap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL1]
        !o_mem_wr_n |-> !o_mem_sel_n && !(o_lower_lane_en_n && o_upper_lane_en_n))
        else $error("strobe low without select and lane");

    // Counter already holds the whole low stretch in the cycle the strobe rises
    a_long_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL2]
        (i_ce && $rose(o_mem_wr_n) && !$past(o_mem_out_drive_n)) |-> (low_cnt_ff >= 4'(WP_LONG_CYC)))
        else $error("write pulse too short with output drive low");

    a_min_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL3]
        (i_ce && $rose(o_mem_wr_n)) |-> (low_cnt_ff >= 4'(WP_CYC)))
        else $error("write pulse below minimum");

    a_no_bus_clash: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL4]
        o_mem_dq_oe |-> (!o_mem_wr_n && (o_mem_out_drive_n || low_cnt_ff >= 4'(FLOAT_CYC))))
        else $error("bus driven outside write window");

    a_addr_stable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL6]
        (i_ce && !o_mem_sel_n && !$past(o_mem_sel_n)) |-> $stable(o_mem_addr))
        else $error("address moved while selected");

    a_read_no_wr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL7]
        (state_ff == ST_READ) |-> o_mem_wr_n)
        else $error("strobe low in read");

    a_read_latency: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL8]
        (i_ce && take && !i_wr) |=> (state_ff == ST_READ) [*7])
        else $error("read shorter than access");

    a_lane_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL10]
        o_mem_sel_n |-> (o_lower_lane_en_n && o_upper_lane_en_n && o_mem_wr_n))
        else $error("lane active while deselected");

    a_short_drive_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL3]
        (!o_mem_wr_n && !keep_od_ff) |-> o_mem_out_drive_n)
        else $error("output drive low in short write");

    // Long strobe only pays off if output drive stays low for all of it
    a_long_drive_held: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL2]
        (!o_mem_wr_n && keep_od_ff) |-> !o_mem_out_drive_n)
        else $error("output drive released in long write");

    a_idle_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL4]
        o_ready |-> (o_mem_sel_n && o_mem_wr_n && !o_mem_dq_oe))
        else $error("pins active while idle");

    a_frozen_pins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL6]
        !i_ce |=> ($stable(o_mem_addr) && $stable(o_mem_sel_n) && $stable(o_mem_wr_n)))
        else $error("pins moved while clock enable low");

    a_rvalid_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL8]
        (i_ce && o_rvalid) |=> !o_rvalid)
        else $error("read valid longer than one cycle");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_read: cover property (@(posedge i_core_clk) o_rvalid);
    c_short_write: cover property (@(posedge i_core_clk) $rose(o_mem_wr_n) && o_mem_out_drive_n);
    c_long_write: cover property (@(posedge i_core_clk) $rose(o_mem_wr_n) && !$past(o_mem_out_drive_n));
    c_frozen_read: cover property (@(posedge i_core_clk) !i_ce && (state_ff == ST_READ));
    c_lane_less: cover property (@(posedge i_core_clk) (state_ff == ST_WRITE) && o_mem_sel_n);
endmodule
`default_nettype wire

/* verif/sram_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sram_dev_model (
    // Pins from the controller
    input wire logic [15:0] i_addr,
    input wire logic i_sel_n,
    input wire logic i_wr_n,
    input wire logic i_out_drive_n,
    input wire logic i_lower_lane_en_n,
    input wire logic i_upper_lane_en_n,
    input wire logic [15:0] i_dq,
    // Pins toward the controller
    output logic [15:0] o_dq,
    output logic [1:0] o_dq_oe
);
    logic [15:0] mem [0:65535];
    wire logic wr_win = !i_sel_n && !i_wr_n;
    wire logic rd_on = !i_sel_n && !i_out_drive_n && i_wr_n;
    // No clock: storage follows the pin overlap alone
    always @* begin
        if (wr_win && !i_lower_lane_en_n) mem[i_addr][7:0] = i_dq[7:0];
        if (wr_win && !i_upper_lane_en_n) mem[i_addr][15:8] = i_dq[15:8];
    end
    assign o_dq = mem[i_addr];
    assign o_dq_oe = {rd_on && !i_upper_lane_en_n, rd_on && !i_lower_lane_en_n};
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sram_port_pkg::*;
    logic i_core_clk = 0, i_rst_n = 0, rq = 0, wr = 0, keep = 0, ce = 1;
    logic [15:0] addr = 16'h0000, wd = 16'h0000, last = 16'h0000, rd, ma, cdq, ddq;
    logic [1:0] lanes = 2'h3, doe;
    logic rdy, rv, sel_n, wr_n, od_n, lo_n, up_n, coe;
    // Undriven lanes flip every cycle so a stale value is never read back
    wire logic [15:0] bus = coe ? cdq : {doe[1] ? ddq[15:8] : ~last[15:8], doe[0] ? ddq[7:0] : ~last[7:0]};
    int bad_count = 0, compares = 0, cyc = 0, n_wr, n_od, n_sel, n_oe;
    sram_host_ctl uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_req(rq), .i_wr(wr),
        .i_addr(addr), .i_wdata(wd), .i_lane_en(lanes), .i_keep_out_drive(keep), .o_ready(rdy),
        .o_rvalid(rv), .o_rdata(rd), .o_mem_addr(ma), .o_mem_sel_n(sel_n), .o_mem_wr_n(wr_n),
        .o_mem_out_drive_n(od_n), .o_lower_lane_en_n(lo_n), .o_upper_lane_en_n(up_n), .o_mem_dq(cdq),
        .o_mem_dq_oe(coe), .i_mem_dq(bus));
    sram_dev_model dev (.i_addr(ma), .i_sel_n(sel_n), .i_wr_n(wr_n), .i_out_drive_n(od_n),
        .i_lower_lane_en_n(lo_n), .i_upper_lane_en_n(up_n), .i_dq(bus), .o_dq(ddq), .o_dq_oe(doe));
    always #2.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        last <= bus;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // One access; pin activity is tallied cycle by cycle until the answer
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] l, input logic k);
        @(negedge i_core_clk);
        chk(rdy, "not ready");
        {rq, wr, addr, wd, lanes, keep} = {1'b1, w, a, d, l, k};
        @(negedge i_core_clk);
        rq = 0;
        n_wr = 0;
        n_od = 0;
        n_sel = 0;
        n_oe = 0;
        for (int i = 0; i < 12 && (w ? rdy : rv) !== 1'b1; i++) begin
            n_wr += int'(!sel_n && !wr_n && !(lo_n && up_n));
            n_sel += int'(!sel_n && !(lo_n && up_n));
            n_od += int'(!od_n);
            n_oe += int'(coe && !wr_n);
            chk(!(coe && doe != 2'h0), "bus contention");
            if (!w) chk(wr_n, "strobe in read");
            if (!sel_n) chk(ma === a, "address moved");
            @(negedge i_core_clk);
        end
        chk(w ? rdy : rv, "no answer");
    endtask
    task automatic t_short();
        access(1, 16'hFFFF, 16'hA5C3, 2'h3, 0);
        chk(n_wr == WP_CYC, "short strobe width");
        chk(n_od == 0 && n_oe >= DW_CYC, "short write drive");
        $display("short write done");
    endtask
    task automatic t_long();
        access(1, 16'hFFFF, 16'h0077, 2'h1, 1);
        chk(n_wr == WP_LONG_CYC && n_od >= n_wr, "long strobe width");
        chk(n_oe >= DW_CYC, "long write setup");
        $display("long write done");
    endtask
    task automatic t_read();
        access(0, 16'hFFFF, 16'h0000, 2'h3, 0);
        chk(rd === 16'hA577 && n_sel == RD_CYC, "word read");
        access(0, 16'hFFFF, 16'h0000, 2'h2, 0);
        chk(rd === 16'hA500, "upper lane read");
        $display("read done");
    endtask
    // Clock enable dropped mid-read must hold select, strobe and address, then the read ends normally
    task automatic t_freeze();
        @(negedge i_core_clk);
        chk(rdy, "not ready");
        {rq, wr, addr, lanes, keep} = {1'b1, 1'b0, 16'hFFFF, 2'h3, 1'b0};
        @(negedge i_core_clk);
        {rq, ce} = 2'h0;
        repeat (8) begin
            @(negedge i_core_clk);
            chk(!sel_n && wr_n && ma === 16'hFFFF && rv === 1'b0, "pins moved while frozen");
        end
        ce = 1;
        for (int i = 0; i < 12 && rv !== 1'b1; i++) @(negedge i_core_clk);
        chk(rv === 1'b1 && rd === 16'hA577, "read after freeze");
        $display("freeze done");
    endtask
    task automatic t_nolane();
        access(1, 16'h0000, 16'h5A5A, 2'h3, 0);
        access(1, 16'h0000, 16'h1111, 2'h0, 0);
        chk(n_sel == 0 && n_wr == 0 && n_oe == 0, "strobe without lanes");
        access(0, 16'h0000, 16'h0000, 2'h1, 0);
        chk(rd === 16'h005A, "lower lane read");
        $display("no lane access done");
    endtask
    initial begin
        repeat (5) @(posedge i_core_clk);
        chk(sel_n && wr_n && !coe && rdy, "reset pins");
        @(negedge i_core_clk);
        i_rst_n = 1;
        t_short();
        t_long();
        t_read();
        t_freeze();
        t_nolane();
        complete_run();
    end
endmodule
`default_nettype wire
